// *** bench/net_partner.sv ***
// Far-side network model: bus message strobes, dynamic id offers, transmit wish.
// Assumes bench commands on sys_clk_i; strobes last one cycle.
`timescale 1ns/1ps
`default_nettype none
module net_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       msg_i,
    input  wire logic       axis_i,
    input  wire logic       dyn_i,
    input  wire logic [6:0] id_i,
    input  wire logic       want_tx_i,
    output logic            msg_valid_o,
    output logic            msg_axis_o,
    output logic            dyn_valid_o,
    output logic [6:0]      dyn_id_o,
    output logic            tx_req_o
);
    // Qualifier lines toggle when nothing is offered, so stale values never match
    always_ff @(posedge clk_i) begin
        msg_valid_o <= msg_i & ~rst_i;
        msg_axis_o  <= rst_i ? 1'h0 : (msg_i ? axis_i : ~msg_axis_o);
        dyn_valid_o <= dyn_i & ~rst_i;
        dyn_id_o    <= rst_i ? 7'h00 : (dyn_i ? id_i : ~dyn_id_o);
        tx_req_o    <= want_tx_i & ~rst_i;
    end
endmodule
`default_nettype wire

// *** bench/tb_drive_enable_and_node_axis_identifier_select.sv ***
// Self-checking bench for the enable gating and node_axis_identifier selection block.
// Assumes the design package and the net_partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_drive_enable_and_node_axis_identifier_select;
    import drive_ctrl_pkg::*;
    logic        sys_clk_i = 1'h0, sys_rst_i = 1'h1, capture_n_i = 1'h1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, encoder_count_i = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF, address_switch_bank_i = 4'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_enable_i = 1'h0;
    logic        conn_enable_i = 1'h0, cmd_msg = 1'h0, cmd_axis = 1'h0, cmd_dyn = 1'h0;
    logic        want_tx = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, rx_msg_valid_i, rx_msg_axis_i, rx_dyn_id_valid_i, tx_req_i;
    logic        rx_accept_o, tx_grant_o, drive_enable_o, preset_active_o, preset_dir_o;
    logic        id_valid_o, chain_enable_o, chain_enable_oe_o;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [6:0]  rx_dyn_id_i, node_axis_identifier_o, cmd_id = 7'h00;
    logic [15:0] preset_cmd_o;
    int          n_errors = 0, compares = 0, cycles = 0;

    // Clock and hang guard
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            $display("ERROR %0t timeout", $time);
            tally_and_finish();
        end
    end

    drive_enable_and_node_axis_identifier_select uut (
        .sys_clk_i, .sys_rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .capture_n_i, .ext_enable_i, .conn_enable_i,
        .address_switch_bank_i, .chain_enable_o, .chain_enable_oe_o, .encoder_count_i,
        .rx_msg_valid_i, .rx_msg_axis_i, .rx_dyn_id_valid_i, .rx_dyn_id_i, .tx_req_i,
        .rx_accept_o, .tx_grant_o, .drive_enable_o, .preset_active_o, .preset_dir_o,
        .preset_cmd_o, .node_axis_identifier_o, .id_valid_o);
    net_partner partner (.clk_i(sys_clk_i), .rst_i(sys_rst_i), .msg_i(cmd_msg),
        .axis_i(cmd_axis), .dyn_i(cmd_dyn), .id_i(cmd_id), .want_tx_i(want_tx),
        .msg_valid_o(rx_msg_valid_i), .msg_axis_o(rx_msg_axis_i),
        .dyn_valid_o(rx_dyn_id_valid_i), .dyn_id_o(rx_dyn_id_i), .tx_req_o(tx_req_i));

    // --------------------------------------------------------------
    // Bus cycles and comparisons
    // --------------------------------------------------------------
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er, "write response");
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        @(posedge sys_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge sys_clk_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        chk(s_axi_rresp, er, "read response");
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, RESP_OKAY, d);
        chk(d, exp, what);
    endtask
    // One message and one transmit wish; answers stand one cycle after the strobe
    task automatic msg(input logic axis, input logic acc, input logic tx);
        @(posedge sys_clk_i);
        cmd_msg <= 1'h1;
        cmd_axis <= axis;
        want_tx <= 1'h1;
        @(posedge sys_clk_i);
        cmd_msg <= 1'h0;
        wait_clk(2);
        chk(rx_accept_o, acc, "message accept");
        chk(tx_grant_o, tx, "transmit grant");
        want_tx <= 1'h0;
    endtask

    initial begin
        logic [31:0] d, res, steps;
        int          sw, base, exp;
        void'($urandom(27337));
        wait_clk(12);
        sys_rst_i <= 1'h0;
        wait_clk(4);
        rchk(OFF_CTRL, 32'h0, "control reset");
        rchk(OFF_STORE_ID, 32'h1, "stored id reset");
        chk(node_axis_identifier_o, 32'h1, "default id");
        wr(8'h40, 32'h0, RESP_SLVERR);
        wr(OFF_CPS, 32'h5, RESP_SLVERR);
        rd(8'h24, RESP_SLVERR, d);
        for (int m = 0; m < 4; m++) begin
            for (int e = 0; e < 2; e++) begin
                wr(OFF_CTRL, 32'(m), RESP_OKAY);
                ext_enable_i <= e[0];
                conn_enable_i <= 1'($urandom);
                wait_clk(5);
                chk(drive_enable_o, m[1] ? e[0] : conn_enable_i, "drive enable");
                msg(1'h1, m[0] == 0 || e == 1, m[0] == 0 || e == 1);
            end
        end
        d = 32'($urandom_range(0, 65535));
        wr(OFF_PRESET, d, RESP_OKAY);
        wr(OFF_CTRL, 32'h71, RESP_OKAY);
        ext_enable_i <= 1'h0;
        conn_enable_i <= 1'h0;
        wait_clk(5);
        chk({preset_active_o, preset_dir_o, drive_enable_o}, 32'h7, "preset mode");
        chk(preset_cmd_o, d, "preset value");
        chk({chain_enable_oe_o, chain_enable_o}, 32'h2, "chain pulled low");
        msg(1'h0, 1'h1, 1'h1);
        wr(OFF_CTRL, 32'h04, RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            sw = (i == 0) ? 0 : (i == 1 ? 15 : $urandom_range(1, 14));
            address_switch_bank_i <= 4'(sw);
            wait_clk(5);
            chk(node_axis_identifier_o, sw, "switch id");
            msg(1'h1, sw != 0, 1'h1);
        end
        chk(chain_enable_oe_o, 32'h0, "chain released");
        wr(OFF_CTRL, 32'h08, RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            base = (i == 0) ? 113 : (i == 1 ? 112 : $urandom_range(0, 127));
            sw = (i < 2) ? 15 : $urandom_range(0, 15);
            wr(OFF_BASE_ID, 32'(base), RESP_OKAY);
            address_switch_bank_i <= 4'(sw);
            wait_clk(5);
            exp = (base + sw > 127) ? 0 : base + sw;
            chk(node_axis_identifier_o, exp, "base plus switch id");
            msg(1'h1, exp != 0, 1'h1);
        end
        d = 32'($urandom_range(1, 127));
        wr(OFF_STORE_ID, d, RESP_OKAY);
        wr(OFF_CTRL, 32'h00, RESP_OKAY);
        wait_clk(3);
        chk(node_axis_identifier_o, d, "stored id");
        rchk(OFF_STORE_ID, d, "stored id readback");
        wr(OFF_CTRL, 32'h0C, RESP_OKAY);
        wait_clk(3);
        chk(id_valid_o, 32'h0, "dynamic id unassigned");
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk_i);
            cmd_dyn <= 1'h1;
            cmd_id <= d[6:0] ^ (i == 0 ? 7'h00 : 7'h2A);
            @(posedge sys_clk_i);
            cmd_dyn <= 1'h0;
            wait_clk(4);
            chk(node_axis_identifier_o, d, "dynamic id first kept");
        end
        for (int i = 0; i < 3; i++) begin
            res = $urandom;
            steps = (i == 0) ? 32'h1 : 32'($urandom_range(2, 65535));
            wr(OFF_ENC_RES, res, RESP_OKAY);
            wr(OFF_STEPS, steps, RESP_OKAY);
            wait_clk(40);
            rchk(OFF_CPS, res / steps, "counts per step");
        end
        d = $urandom;
        encoder_count_i <= d;
        wait_clk(2);
        capture_n_i <= 1'h0;
        wait_clk(8);
        encoder_count_i <= ~d;
        capture_n_i <= 1'h1;
        wait_clk(8);
        rchk(OFF_SNAP, d, "capture snapshot");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** design/drive_ctrl_pkg.sv ***
// Constants, register map and mode encodings for the drive enable and
// axis identifier block.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package drive_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_STORE_ID = 8'h04;
    localparam logic [7:0] OFF_BASE_ID  = 8'h08;
    localparam logic [7:0] OFF_ENC_RES  = 8'h0C;
    localparam logic [7:0] OFF_STEPS    = 8'h10;
    localparam logic [7:0] OFF_CPS      = 8'h14;
    localparam logic [7:0] OFF_SNAP     = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1C;
    localparam logic [7:0] OFF_PRESET   = 8'h20;

    // Control register fields
    localparam int CTRL_EN_LSB  = 0;
    localparam int CTRL_ID_LSB  = 2;
    localparam int CTRL_NO_IO   = 4;
    localparam int CTRL_DIR     = 5;
    localparam int CTRL_CHAIN   = 6;

    // Reset values and axis identifier limit
    localparam logic [6:0]  RST_STORE_ID = 7'h01;
    localparam logic [6:0]  RST_BASE_ID  = 7'h00;
    localparam logic [31:0] RST_ENC_RES  = 32'h0000_1000;
    localparam logic [15:0] RST_STEPS    = 16'h00C8;
    localparam logic [15:0] RST_PRESET   = 16'h0000;
    localparam logic [6:0]  ID_MAX       = 7'h7F;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Divider length in cycles
    localparam logic [5:0] DIV_STEPS = 6'h20;

    typedef enum logic [1:0] {
        EN_UNUSED = 2'b00,
        EN_BUS    = 2'b01,
        EN_DRIVE  = 2'b10,
        EN_BOTH   = 2'b11
    } en_mode_t;

    typedef enum logic [1:0] {
        ID_STORED = 2'b00,
        ID_SWITCH = 2'b01,
        ID_BASE   = 2'b10,
        ID_DYN    = 2'b11
    } id_mode_t;
endpackage

// *** design/drive_enable_and_node_axis_identifier_select.sv ***
// Enable gating, axis identifier selection, capture snapshot and step
// scaling for a servo drive, with an AXI4-Lite register slave.
// Assumes pins arrive asynchronously and bus message strobes and the
// encoder count come from logic on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

module drive_enable_and_node_axis_identifier_select
    import drive_ctrl_pkg::*;
(
    input  wire  logic        sys_clk_i,
    input  wire  logic        sys_rst_i,
    // AXI4-Lite slave
    input  wire  logic [7:0]  s_axi_awaddr,
    input  wire  logic        s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire  logic [31:0] s_axi_wdata,
    input  wire  logic [3:0]  s_axi_wstrb,
    input  wire  logic        s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire  logic        s_axi_bready,
    input  wire  logic [7:0]  s_axi_araddr,
    input  wire  logic        s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire  logic        s_axi_rready,
    // Pins
    input  wire  logic        capture_n_i,
    input  wire  logic        ext_enable_i,
    input  wire  logic        conn_enable_i,
    input  wire  logic [3:0]  address_switch_bank_i,
    output logic              chain_enable_o,
    output logic              chain_enable_oe_o,
    // Core side
    input  wire  logic [31:0] encoder_count_i,
    input  wire  logic        rx_msg_valid_i,
    input  wire  logic        rx_msg_axis_i,
    input  wire  logic        rx_dyn_id_valid_i,
    input  wire  logic [6:0]  rx_dyn_id_i,
    input  wire  logic        tx_req_i,
    output logic              rx_accept_o,
    output logic              tx_grant_o,
    output logic              drive_enable_o,
    output logic              preset_active_o,
    output logic              preset_dir_o,
    output logic [15:0]       preset_cmd_o,
    output logic [6:0]        node_axis_identifier_o,
    output logic              id_valid_o
);
    import drive_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [6:0] meta_q;
    logic [6:0] sync_q;
    logic       cap_prev_q;

    // Two stages for every pin before use
    always_ff @(posedge sys_clk_i) begin
        meta_q     <= {capture_n_i, ext_enable_i, conn_enable_i,
                       address_switch_bank_i};
        sync_q     <= meta_q;
        cap_prev_q <= sync_q[6];
    end

    wire       cap_s   = sync_q[6];
    wire       ext_s   = sync_q[5];
    wire       conn_s  = sync_q[4];
    wire [3:0] sw_s    = sync_q[3:0];
    wire       cap_fall = cap_prev_q & ~cap_s;

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [6:0]  ctrl_q;
    logic [6:0]  store_id_q;
    logic [6:0]  base_id_q;
    logic [31:0] enc_res_q;
    logic [15:0] steps_q;
    logic [15:0] preset_q;
    logic [31:0] snap_q;
    logic [31:0] cps_q;

    wire en_mode_t en_mode = en_mode_t'(ctrl_q[CTRL_EN_LSB +: 2]);
    wire id_mode_t id_mode = id_mode_t'(ctrl_q[CTRL_ID_LSB +: 2]);
    wire           no_io   = ctrl_q[CTRL_NO_IO];

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    logic        aw_got_q;
    logic        w_got_q;
    logic [7:0]  waddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    wire aw_hs   = s_axi_awvalid & s_axi_awready;
    wire w_hs    = s_axi_wvalid & s_axi_wready;
    wire wr_go   = aw_got_q & w_got_q & ~s_axi_bvalid;
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                         {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire wr_ctrl  = wr_go & (waddr_q == OFF_CTRL);
    wire wr_store = wr_go & (waddr_q == OFF_STORE_ID);
    wire wr_base  = wr_go & (waddr_q == OFF_BASE_ID);
    wire wr_res   = wr_go & (waddr_q == OFF_ENC_RES);
    wire wr_steps = wr_go & (waddr_q == OFF_STEPS);
    wire wr_pre   = wr_go & (waddr_q == OFF_PRESET);
    wire wr_ok    = wr_ctrl | wr_store | wr_base | wr_res | wr_steps | wr_pre;
    wire [31:0] wmerged_res = (enc_res_q & ~wmask) | (wdata_q & wmask);
    wire [31:0] wnew = wdata_q & wmask;

    // Address and data taken in either order, response after both
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            waddr_q       <= 8'h00;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_got_q & ~aw_hs;
            s_axi_wready  <= ~w_got_q & ~w_hs;
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                waddr_q  <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable configuration; store id defaults to factory value
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ctrl_q     <= 7'h00;
            store_id_q <= RST_STORE_ID;
            base_id_q  <= RST_BASE_ID;
            enc_res_q  <= RST_ENC_RES;
            steps_q    <= RST_STEPS;
            preset_q   <= RST_PRESET;
        end else begin
            if (wr_ctrl & wstrb_q[0]) ctrl_q <= wdata_q[6:0];
            if (wr_store & wstrb_q[0]) store_id_q <= wdata_q[6:0];
            if (wr_base & wstrb_q[0]) base_id_q <= wdata_q[6:0];
            if (wr_res) enc_res_q <= wmerged_res;
            if (wr_steps) steps_q <= (steps_q & ~wmask[15:0]) | wnew[15:0];
            if (wr_pre) preset_q <= (preset_q & ~wmask[15:0]) | wnew[15:0];
        end
    end

    // ----------------------------------------------------------------
    // Capture snapshot
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            snap_q <= 32'h0000_0000;
        end else if (cap_fall) begin
            snap_q <= encoder_count_i;
        end
    end

    // ----------------------------------------------------------------
    // Counts per step divider (restoring, one bit a cycle)
    // ----------------------------------------------------------------
    logic        busy_q;
    logic [5:0]  div_cnt_q;
    logic [32:0] rem_q;
    logic [31:0] quo_q;
    logic        div_kick_q;

    wire [32:0] rem_sh  = {rem_q[31:0], quo_q[31]};
    wire [32:0] rem_sub = rem_sh - {17'h0_0000, steps_q};
    wire        take    = ~rem_sub[32];

    // Restart after every resolution or steps write
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            div_kick_q <= 1'b1;
            busy_q     <= 1'b0;
            div_cnt_q  <= 6'h00;
            rem_q      <= 33'h0_0000_0000;
            quo_q      <= 32'h0000_0000;
            cps_q      <= 32'h0000_0000;
        end else begin
            div_kick_q <= wr_res | wr_steps;
            if (div_kick_q) begin
                busy_q    <= (steps_q != 16'h0000);
                div_cnt_q <= DIV_STEPS;
                rem_q     <= 33'h0_0000_0000;
                quo_q     <= enc_res_q;
                if (steps_q == 16'h0000) cps_q <= 32'hFFFF_FFFF;
            end else if (busy_q) begin
                rem_q     <= take ? rem_sub : rem_sh;
                quo_q     <= {quo_q[30:0], take};
                div_cnt_q <= div_cnt_q - 6'h01;
                if (div_cnt_q == 6'h01) begin
                    busy_q <= 1'b0;
                    cps_q  <= {quo_q[30:0], take};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Enable mode decode
    // ----------------------------------------------------------------
    wire bus_gated = (en_mode == EN_BUS) | (en_mode == EN_BOTH);
    wire drv_ext   = (en_mode == EN_DRIVE) | (en_mode == EN_BOTH);
    wire bus_en_w  = no_io | ~bus_gated | ext_s;
    wire drv_en_w  = no_io | (drv_ext ? ext_s : conn_s);

    // ----------------------------------------------------------------
    // Axis identifier selection
    // ----------------------------------------------------------------
    logic [6:0] dyn_id_q;
    logic       dyn_done_q;

    wire [7:0] base_sum = {1'b0, base_id_q} + {4'h0, sw_s};
    wire       sum_ovf  = base_sum > {1'b0, ID_MAX};
    wire [6:0] id_sel =
        (id_mode == ID_SWITCH) ? {3'b000, sw_s} :
        (id_mode == ID_BASE)   ? (sum_ovf ? 7'h00 : base_sum[6:0]) :
        (id_mode == ID_DYN)    ? dyn_id_q :
                                 store_id_q;

    // First dynamic assignment after power up is kept
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dyn_id_q   <= 7'h00;
            dyn_done_q <= 1'b0;
        end else if (rx_dyn_id_valid_i & bus_en_w & ~dyn_done_q) begin
            dyn_id_q   <= rx_dyn_id_i;
            dyn_done_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    wire rx_ok = rx_msg_valid_i & bus_en_w &
                 (~rx_msg_axis_i | (node_axis_identifier_o != 7'h00));

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rx_accept_o            <= 1'b0;
            tx_grant_o             <= 1'b0;
            drive_enable_o         <= 1'b0;
            preset_active_o        <= 1'b0;
            preset_dir_o           <= 1'b0;
            preset_cmd_o           <= 16'h0000;
            node_axis_identifier_o <= RST_STORE_ID;
            id_valid_o             <= 1'b0;
            chain_enable_o         <= 1'b0;
            chain_enable_oe_o      <= 1'b0;
        end else begin
            rx_accept_o            <= rx_ok;
            tx_grant_o             <= tx_req_i & bus_en_w;
            drive_enable_o         <= drv_en_w;
            preset_active_o        <= no_io;
            preset_dir_o           <= ctrl_q[CTRL_DIR];
            preset_cmd_o           <= preset_q;
            node_axis_identifier_o <= id_sel;
            id_valid_o             <= (id_sel != 7'h00);
            chain_enable_o         <= 1'b0;
            chain_enable_oe_o      <= ctrl_q[CTRL_CHAIN];
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    wire [7:0] raddr = {s_axi_araddr[7:2], 2'b00};
    wire [31:0] status_w = {16'h0000, sw_s, busy_q, bus_en_w, drv_en_w,
                            ext_s, id_valid_o, node_axis_identifier_o};
    wire rd_hit = (raddr <= OFF_PRESET);
    wire [31:0] rd_mux =
        (raddr == OFF_CTRL)     ? {25'h0, ctrl_q} :
        (raddr == OFF_STORE_ID) ? {25'h0, store_id_q} :
        (raddr == OFF_BASE_ID)  ? {25'h0, base_id_q} :
        (raddr == OFF_ENC_RES)  ? enc_res_q :
        (raddr == OFF_STEPS)    ? {16'h0000, steps_q} :
        (raddr == OFF_CPS)      ? cps_q :
        (raddr == OFF_SNAP)     ? snap_q :
        (raddr == OFF_STATUS)   ? status_w :
        (raddr == OFF_PRESET)   ? {16'h0000, preset_q} :
                                  32'h0000_0000;

    // One read at a time; data held until accepted
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid  <= ~s_axi_rready;
            s_axi_arready <= s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence cap_edge_s;
        cap_prev_q && !cap_s;
    endsequence

    chk_capture_snap: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        cap_edge_s |=> snap_q == $past(encoder_count_i))
        else $error("snapshot missed capture edge");

    chk_no_io_run: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (no_io && !ext_s && !conn_s) |=> drive_enable_o && preset_active_o)
        else $error("preset mode did not run drive");

    chk_div_value: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        ($fell(busy_q) && !div_kick_q) |-> cps_q == enc_res_q / {16'h0000, steps_q})
        else $error("counts per step wrong");

    chk_unused_mode: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (en_mode == EN_UNUSED && tx_req_i) |=> tx_grant_o)
        else $error("unused enable blocked bus");

    sequence bus_closed_s;
        bus_gated && !ext_s && !no_io;
    endsequence

    chk_bus_block: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        bus_closed_s |=> !rx_accept_o && !tx_grant_o)
        else $error("bus traffic while disabled");

    chk_drive_src: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (en_mode == EN_DRIVE && !no_io) |=> drive_enable_o == $past(ext_s))
        else $error("drive enable not from external input");

    chk_both_gate: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (en_mode == EN_BOTH && !no_io && !ext_s && tx_req_i)
        |=> !drive_enable_o && !tx_grant_o)
        else $error("combined mode not gating both");

    chk_chain_drive: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        chain_enable_oe_o |-> !chain_enable_o && $past(ctrl_q[CTRL_CHAIN]))
        else $error("chain output not pulled low");

    chk_zero_id: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (rx_msg_valid_i && rx_msg_axis_i && node_axis_identifier_o == 7'h00)
        |=> !rx_accept_o)
        else $error("axis message accepted with id zero");

    chk_switch_id: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (id_mode == ID_SWITCH) |=> node_axis_identifier_o == {3'b000, $past(sw_s)})
        else $error("switch id mismatch");

    chk_sum_limit: assert property (
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (id_mode == ID_BASE && sum_ovf) |=> !id_valid_o)
        else $error("overflowed sum used as id");
endmodule

`default_nettype wire
